// File: logic/adpcm_channel_core.sv
// channel core: init, warm and power-on reset, nop and serial outputs
// Overview of operation
// - extra shift clocks recirculate code word from msb
// - four-bit words repeat by four, 40k by five
// - init pin or reset loads channel defaults
// - config and init sampled at strobe fall
// - host gives init slots at least 45 cycles
// - 726 cycles of memory init after warm reset
// - host waits six cycles before strobing
// - host idles strobe low, clocks high, data low
// - serial input during init is discarded
// - host holds warm reset low two cycles
// - processing resumes at first strobe fall after
// - power-on reset initializes all, 2000 cycles
// - outputs released during any reset process
// - enable low skips channel, keeps its state
// - host gives nop slots at least 4 cycles
// - nop drives known outputs, gates state writes
// - nop code output stays low
// - nop pcm output ff mu-law, d5 a-law
// - direction picks input and later output
// - all serial words move msb first
`timescale 1ns/1ps
`include "adpcm_link_map.svh"
module adpcm_channel_core
	import adpcm_link_pkg::*;
(
	input logic hclk,
	input logic hresetn,
	input logic clk_en,
	adpcm_link_if.device link,
	output logic init_busy,
	output logic [2:0] active_channel
);
	logic [11:0] link_raw;
	logic [11:0] sync1_reg;
	logic [11:0] sync2_reg;
	logic [2:0] edge_d_reg;
	logic warm_s, aclk_s, pclk_s, strobe_s, dir_s, law_s, init_s, en_s;
	logic ain_s, pin_s;
	rate_t rate_s;
	logic strobe_fall, pclk_fall, pclk_rise, aclk_fall, aclk_rise;
	core_phase_t phase_reg;
	logic [11:0] init_cnt_reg;
	logic run;
	logic [7:0] pcm_in_reg;
	logic [4:0] adpcm_in_reg;
	chan_state_t chan_mem [8];
	logic [2:0] chan_reg;
	logic proc_valid_reg, proc_dir_reg, proc_en_reg, proc_init_reg;
	law_t proc_law_reg;
	rate_t proc_rate_reg;
	logic [2:0] proc_chan_reg;
	logic [7:0] proc_pcm_reg;
	logic [4:0] proc_adpcm_reg;
	logic out_valid_reg, out_dir_reg;
	rate_t out_rate_reg;
	logic [4:0] adpcm_out_reg;
	logic [7:0] pcm_out_reg;
	chan_state_t cur;
	law_t eff_law;
	rate_t eff_rate;
	logic [4:0] mask;
	logic [4:0] in_left;
	logic [4:0] enc_word;
	logic [7:0] dec_word;
	logic [7:0] new_pred;
	logic live;

	// every input pin passes two flops; only stage two is read below
	assign link_raw = {link.warm_reset_n, link.adpcm_shift_clock,
		link.pcm_shift_clock, link.channel_strobe, link.direction_select,
		link.companding_law_select, link.rate_select_msb,
		link.rate_select_lsb, link.channel_init, link.channel_enable,
		link.adpcm_serial_in, link.pcm_serial_in};
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_reg <= `LINK_SYNC_RESET;
			sync2_reg <= `LINK_SYNC_RESET;
		end else if (clk_en) begin
			sync1_reg <= link_raw;
			sync2_reg <= sync1_reg;
		end
	end

	assign warm_s = sync2_reg[11];
	assign aclk_s = sync2_reg[10];
	assign pclk_s = sync2_reg[9];
	assign strobe_s = sync2_reg[8];
	assign dir_s = sync2_reg[7];
	assign law_s = sync2_reg[6];
	assign rate_s = rate_t'(sync2_reg[5:4]);
	assign init_s = sync2_reg[3];
	assign en_s = sync2_reg[2];
	assign ain_s = sync2_reg[1];
	assign pin_s = sync2_reg[0];

	// edge finders on the synchronised strobe and shift clocks
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			edge_d_reg <= `EDGE_RESET;
		end else if (clk_en) begin
			edge_d_reg <= {aclk_s, pclk_s, strobe_s};
		end
	end
	assign strobe_fall = edge_d_reg[0] & ~strobe_s;
	assign pclk_fall = edge_d_reg[1] & ~pclk_s;
	assign pclk_rise = ~edge_d_reg[1] & pclk_s;
	assign aclk_fall = edge_d_reg[2] & ~aclk_s;
	assign aclk_rise = ~edge_d_reg[2] & aclk_s;

	// init sequencing: power-on length after hresetn, warm length after pin
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_reg <= PH_INIT;
			init_cnt_reg <= `POR_INIT_CYCLES;
		end else if (clk_en) begin
			case (phase_reg)
				PH_INIT: begin
					if (!warm_s) begin
						init_cnt_reg <= `WARM_INIT_CYCLES;
					end else if (init_cnt_reg == 12'd1) begin
						init_cnt_reg <= 12'd0;
						phase_reg <= PH_RUN;
					end else begin
						init_cnt_reg <= init_cnt_reg - 12'd1;
					end
				end
				PH_RUN: begin
					if (!warm_s) begin
						init_cnt_reg <= `WARM_INIT_CYCLES;
						phase_reg <= PH_INIT;
					end
				end
				default: phase_reg <= PH_INIT;
			endcase
		end
	end
	assign run = (phase_reg == PH_RUN);
	assign init_busy = ~run;
	assign active_channel = chan_reg;

	// serial input registers, shifted on falling shift clock edges
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pcm_in_reg <= 8'h00;
			adpcm_in_reg <= 5'h00;
		end else if (clk_en) begin
			if (!run) begin
				pcm_in_reg <= 8'h00;
				adpcm_in_reg <= 5'h00;
			end else if (strobe_s) begin
				if (dir_s && pclk_fall) begin
					pcm_in_reg <= {pcm_in_reg[6:0], pin_s};
				end
				if (!dir_s && aclk_fall) begin
					adpcm_in_reg <= {adpcm_in_reg[3:0], ain_s};
				end
			end
		end
	end

	// slot pipeline: captured at one fall, processed until the next
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			proc_valid_reg <= 1'b0;
			proc_dir_reg <= 1'b0;
			proc_en_reg <= 1'b0;
			proc_init_reg <= 1'b0;
			proc_law_reg <= LAW_MU;
			proc_rate_reg <= RATE_32K;
			proc_chan_reg <= 3'h0;
			proc_pcm_reg <= 8'h00;
			proc_adpcm_reg <= 5'h00;
			chan_reg <= 3'h0;
		end else if (clk_en) begin
			if (!run) begin
				proc_valid_reg <= 1'b0;
				chan_reg <= 3'h0;
			end else if (strobe_fall) begin
				proc_valid_reg <= 1'b1;
				proc_dir_reg <= dir_s;
				proc_en_reg <= en_s;
				proc_init_reg <= init_s;
				proc_law_reg <= law_t'(law_s);
				proc_rate_reg <= rate_s;
				proc_chan_reg <= chan_reg;
				proc_pcm_reg <= pcm_in_reg;
				proc_adpcm_reg <= adpcm_in_reg;
				chan_reg <= chan_reg + 3'h1;
			end
		end
	end

	// transcoding stand-in; config comes from channel memory except on init
	always_comb begin
		cur = chan_mem[proc_chan_reg];
		eff_law = proc_init_reg ? proc_law_reg : cur.law;
		eff_rate = proc_init_reg ? proc_rate_reg : cur.rate;
		case (eff_rate)
			RATE_40K: mask = `MASK_40K;
			RATE_24K: mask = `MASK_24K;
			RATE_16K: mask = `MASK_16K;
			default: mask = `MASK_32K;
		endcase
		// four-bit modes take the last four bits, 40k the last five
		if (eff_rate == RATE_40K) begin
			in_left = proc_adpcm_reg;
		end else begin
			in_left = {proc_adpcm_reg[3:0], 1'b0};
		end
		enc_word = (proc_pcm_reg[7:3] ^ cur.predictor[7:3]) & mask;
		dec_word = {in_left & mask, 3'b000} ^ cur.predictor;
		new_pred = proc_dir_reg ? proc_pcm_reg : dec_word;
		live = proc_en_reg & ~proc_init_reg;
		if (!live) begin
			enc_word = `NOP_ADPCM;
			dec_word = (eff_law == LAW_A) ? `NOP_PCM_A : `NOP_PCM_MU;
		end
	end

	// channel memory: cleared on every init cycle, written only by init slots and live slots
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 8; i++) begin
				chan_mem[i] <= {LAW_MU, RATE_32K, `PREDICTOR_DEFAULT};
			end
		end else if (clk_en) begin
			if (!run) begin
				for (int i = 0; i < 8; i++) begin
					chan_mem[i] <= {LAW_MU, RATE_32K, `PREDICTOR_DEFAULT};
				end
			end else if (strobe_fall && proc_valid_reg) begin
				if (proc_init_reg) begin
					chan_mem[proc_chan_reg] <= {proc_law_reg, proc_rate_reg,
						`PREDICTOR_DEFAULT};
				end else if (proc_en_reg) begin
					chan_mem[proc_chan_reg].predictor <= new_pred;
				end
				// a disabled slot writes nothing, so its state survives
			end
		end
	end

	// output shift registers, loaded at the fall, rotated on rising edges
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_valid_reg <= 1'b0;
			out_dir_reg <= 1'b0;
			out_rate_reg <= RATE_32K;
			adpcm_out_reg <= 5'h00;
			pcm_out_reg <= 8'h00;
		end else if (clk_en) begin
			if (!run) begin
				out_valid_reg <= 1'b0;
			end else if (strobe_fall) begin
				out_valid_reg <= proc_valid_reg;
				out_dir_reg <= proc_dir_reg;
				out_rate_reg <= eff_rate;
				adpcm_out_reg <= enc_word;
				pcm_out_reg <= dec_word;
			end else if (strobe_s) begin
				if (aclk_rise) begin
					if (out_rate_reg == RATE_40K) begin
						adpcm_out_reg <= {adpcm_out_reg[3:0],
							adpcm_out_reg[4]};
					end else begin
						adpcm_out_reg <= {adpcm_out_reg[3:1],
							adpcm_out_reg[4], adpcm_out_reg[0]};
					end
				end
				if (pclk_rise) begin
					pcm_out_reg <= {pcm_out_reg[6:0], pcm_out_reg[7]};
				end
			end
		end
	end

	// the msb shows as soon as the strobe rises; only one output drives
	assign link.adpcm_serial_out = adpcm_out_reg[4];
	assign link.pcm_serial_out = pcm_out_reg[7];
	assign link.adpcm_serial_out_oe = run & strobe_s & out_valid_reg
		& out_dir_reg;
	assign link.pcm_serial_out_oe = run & strobe_s & out_valid_reg
		& ~out_dir_reg;
endmodule : adpcm_channel_core

// File: logic/adpcm_link_if.sv
// pins between the frame timing controller and the channel core
`timescale 1ns/1ps
interface adpcm_link_if;
	logic channel_strobe;
	logic direction_select;
	logic companding_law_select;
	logic rate_select_lsb;
	logic rate_select_msb;
	logic channel_init;
	logic channel_enable;
	logic warm_reset_n;
	logic pcm_shift_clock;
	logic adpcm_shift_clock;
	logic pcm_serial_in;
	logic adpcm_serial_in;
	logic pcm_serial_out;
	logic pcm_serial_out_oe;
	logic adpcm_serial_out;
	logic adpcm_serial_out_oe;
	modport device (
		input channel_strobe, direction_select, companding_law_select,
		input rate_select_lsb, rate_select_msb, channel_init, channel_enable,
		input warm_reset_n, pcm_shift_clock, adpcm_shift_clock,
		input pcm_serial_in, adpcm_serial_in,
		output pcm_serial_out, pcm_serial_out_oe,
		output adpcm_serial_out, adpcm_serial_out_oe
	);
	modport host (
		output channel_strobe, direction_select, companding_law_select,
		output rate_select_lsb, rate_select_msb, channel_init, channel_enable,
		output warm_reset_n, pcm_shift_clock, adpcm_shift_clock,
		output pcm_serial_in, adpcm_serial_in,
		input pcm_serial_out, pcm_serial_out_oe,
		input adpcm_serial_out, adpcm_serial_out_oe
	);
endinterface : adpcm_link_if

// File: logic/adpcm_link_map.svh
// constants shared by both ends of the adpcm channel link
`ifndef ADPCM_LINK_MAP_SVH
`define ADPCM_LINK_MAP_SVH

// clock rates and link shift clock timing
`define HCLK_PERIOD_NS 40
`define LINK_CLK_PERIOD_NS 320
`define SHIFT_HALF_CYCLES (`LINK_CLK_PERIOD_NS / (2 * `HCLK_PERIOD_NS))

// initialization and slot timing, in master clock cycles
`define POR_INIT_CYCLES 12'd2000
`define WARM_INIT_CYCLES 12'd726
`define WARM_LOW_CYCLES 12'd2
`define START_GAP_CYCLES 12'd6
`define HOST_SYNC_MARGIN 12'd4
`define INIT_SLOT_CYCLES 12'd45
`define NOP_SLOT_CYCLES 12'd4
`define SLOT_LEAD_CYCLES 12'd4
`define SLOT_LOW_CYCLES 12'd64
`define SHIFT_PULSES 4'd8

// synchroniser reset value: warm reset and both shift clocks idle high
`define LINK_SYNC_RESET 12'he00
`define EDGE_RESET 3'b110

// fixed words and per-rate masks of the left-aligned 5-bit code word
`define NOP_PCM_MU 8'hff
`define NOP_PCM_A 8'hd5
`define NOP_ADPCM 5'h00
`define MASK_40K 5'h1f
`define MASK_32K 5'h1e
`define MASK_24K 5'h1c
`define MASK_16K 5'h18
`define PREDICTOR_DEFAULT 8'h00

// controller register offsets and fields
`define CTRL_OFFSET 12'h000
`define TXDATA_OFFSET 12'h004
`define STATUS_OFFSET 12'h008
`define CTRL_GO 0
`define CTRL_INIT 1
`define CTRL_EN 2
`define CTRL_LAW 3
`define CTRL_RATE_LSB 4
`define CTRL_RATE_MSB 5
`define CTRL_DIR 6
`define CTRL_WARM 7
`define CTRL_RESET 8'h00

`endif

// File: logic/adpcm_link_pkg.sv
// types shared by both ends of the adpcm channel link
package adpcm_link_pkg;
	typedef enum logic [1:0] {
		RATE_32K = 2'b00,
		RATE_24K = 2'b01,
		RATE_16K = 2'b10,
		RATE_40K = 2'b11
	} rate_t;
	typedef enum logic {LAW_MU = 1'b0, LAW_A = 1'b1} law_t;
	typedef enum logic {PH_INIT, PH_RUN} core_phase_t;
	typedef enum logic [2:0] {
		H_IDLE, H_RST_LOW, H_RST_WAIT, H_LEAD, H_SHIFT_LO, H_SHIFT_HI, H_LOW
	} host_state_t;
	typedef struct packed {
		law_t law;
		rate_t rate;
		logic [7:0] predictor;
	} chan_state_t;
endpackage : adpcm_link_pkg

// File: logic/adpcm_slot_host.sv
// frame timing controller: ahb-lite registers drive one link slot
`timescale 1ns/1ps
`include "adpcm_link_map.svh"
module adpcm_slot_host
	import adpcm_link_pkg::*;
(
	input logic hclk,
	input logic hresetn,
	input logic clk_en,
	input logic hsel,
	input logic [31:0] haddr,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic [2:0] hsize,
	input logic [31:0] hwdata,
	input logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	adpcm_link_if.host link
);
	host_state_t state_reg;
	logic [11:0] cnt_reg;
	logic [3:0] pulse_reg;
	logic [7:0] ctrl_reg;
	logic [15:0] tx_reg;
	logic [7:0] pcm_tx_reg, adpcm_tx_reg;
	logic [7:0] pcm_rx_reg, adpcm_rx_reg;
	logic pcm_seen_reg, adpcm_seen_reg;
	logic [23:0] status_reg;
	logic wr_pend_reg;
	logic [11:0] wr_addr_reg;
	logic strobe_reg, sclk_reg, warm_n_reg;
	logic go_req, warm_req, busy, accept;
	logic [31:0] rd_value;
	logic [11:0] half;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign half = 12'(`SHIFT_HALF_CYCLES);
	assign accept = hsel & hready & htrans[1];
	assign busy = (state_reg != H_IDLE);
	assign go_req = wr_pend_reg & (wr_addr_reg == `CTRL_OFFSET)
		& hwdata[`CTRL_GO];
	assign warm_req = wr_pend_reg & (wr_addr_reg == `CTRL_OFFSET)
		& hwdata[`CTRL_WARM];

	// read mux for the address phase; unmapped offsets read zero
	always_comb begin
		if (haddr[11:0] == `CTRL_OFFSET) begin
			rd_value = {24'h0, ctrl_reg};
		end else if (haddr[11:0] == `TXDATA_OFFSET) begin
			rd_value = {16'h0, tx_reg};
		end else if (haddr[11:0] == `STATUS_OFFSET) begin
			rd_value = {8'h0, status_reg[23:1], busy};
		end else begin
			rd_value = 32'h0;
		end
	end

	// bus slave: zero wait states, writes land in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 12'h0;
			hrdata <= 32'h0;
			ctrl_reg <= `CTRL_RESET;
			tx_reg <= 16'h0;
		end else if (clk_en) begin
			wr_pend_reg <= accept & hwrite;
			if (accept) begin
				wr_addr_reg <= haddr[11:0];
			end
			if (accept && !hwrite) begin
				hrdata <= rd_value;
			end
			// go and warm reset are pulses and are not stored
			if (wr_pend_reg && wr_addr_reg == `CTRL_OFFSET) begin
				ctrl_reg <= {1'b0, hwdata[6:1], 1'b0};
			end else if (wr_pend_reg && wr_addr_reg == `TXDATA_OFFSET) begin
				tx_reg <= hwdata[15:0];
			end
		end
	end

	// slot and reset sequencer; a request while busy is ignored
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= H_IDLE;
			cnt_reg <= 12'h0;
			pulse_reg <= 4'h0;
			strobe_reg <= 1'b0;
			sclk_reg <= 1'b1;
			warm_n_reg <= 1'b1;
		end else if (clk_en) begin
			case (state_reg)
				H_IDLE: begin
					if (warm_req) begin
						warm_n_reg <= 1'b0;
						cnt_reg <= `WARM_LOW_CYCLES;
						state_reg <= H_RST_LOW;
					end else if (go_req) begin
						strobe_reg <= 1'b1;
						cnt_reg <= `SLOT_LEAD_CYCLES;
						pulse_reg <= 4'h0;
						state_reg <= H_LEAD;
					end
				end
				H_RST_LOW: begin
					if (cnt_reg == 12'd1) begin
						warm_n_reg <= 1'b1;
						cnt_reg <= `WARM_INIT_CYCLES + `START_GAP_CYCLES
							+ `HOST_SYNC_MARGIN;
						state_reg <= H_RST_WAIT;
					end else begin
						cnt_reg <= cnt_reg - 12'd1;
					end
				end
				H_RST_WAIT, H_LOW: begin
					if (cnt_reg == 12'd1) begin
						state_reg <= H_IDLE;
					end else begin
						cnt_reg <= cnt_reg - 12'd1;
					end
				end
				H_LEAD, H_SHIFT_HI: begin
					if (cnt_reg != 12'd1) begin
						cnt_reg <= cnt_reg - 12'd1;
					end else if (pulse_reg == `SHIFT_PULSES) begin
						strobe_reg <= 1'b0;
						cnt_reg <= `SLOT_LOW_CYCLES;
						state_reg <= H_LOW;
					end else begin
						sclk_reg <= 1'b0;
						cnt_reg <= half;
						state_reg <= H_SHIFT_LO;
					end
				end
				H_SHIFT_LO: begin
					if (cnt_reg == 12'd1) begin
						sclk_reg <= 1'b1;
						pulse_reg <= pulse_reg + 4'h1;
						cnt_reg <= half;
						state_reg <= H_SHIFT_HI;
					end else begin
						cnt_reg <= cnt_reg - 12'd1;
					end
				end
				default: state_reg <= H_IDLE;
			endcase
		end
	end

	// serial data: new bit after each rise, device outputs read at each fall
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pcm_tx_reg <= 8'h0;
			adpcm_tx_reg <= 8'h0;
			pcm_rx_reg <= 8'h0;
			adpcm_rx_reg <= 8'h0;
			pcm_seen_reg <= 1'b0;
			adpcm_seen_reg <= 1'b0;
			status_reg <= 24'h0;
		end else if (clk_en) begin
			if (state_reg == H_IDLE && !warm_req && go_req) begin
				// ctrl_reg only takes the new word at this edge, so use hwdata
				pcm_tx_reg <= hwdata[`CTRL_DIR] ? tx_reg[7:0] : 8'h0;
				adpcm_tx_reg <= hwdata[`CTRL_DIR] ? 8'h0 : tx_reg[15:8];
				pcm_seen_reg <= 1'b0;
				adpcm_seen_reg <= 1'b0;
			end else if (state_reg == H_SHIFT_LO && cnt_reg == 12'd1) begin
				pcm_tx_reg <= {pcm_tx_reg[6:0], 1'b0};
				adpcm_tx_reg <= {adpcm_tx_reg[6:0], 1'b0};
			end else if ((state_reg == H_LEAD || state_reg == H_SHIFT_HI)
				&& cnt_reg == 12'd1 && pulse_reg != `SHIFT_PULSES) begin
				if (link.pcm_serial_out_oe) begin
					pcm_rx_reg <= {pcm_rx_reg[6:0], link.pcm_serial_out};
					pcm_seen_reg <= 1'b1;
				end
				if (link.adpcm_serial_out_oe) begin
					adpcm_rx_reg <= {adpcm_rx_reg[6:0], link.adpcm_serial_out};
					adpcm_seen_reg <= 1'b1;
				end
			end else if (state_reg == H_SHIFT_HI && cnt_reg == 12'd1) begin
				status_reg <= {adpcm_rx_reg, pcm_rx_reg, 5'h0,
					adpcm_seen_reg, pcm_seen_reg, 1'b0};
			end
		end
	end

	// pins; data idles low and clocks idle high between slots
	assign link.channel_strobe = strobe_reg;
	assign link.pcm_shift_clock = sclk_reg;
	assign link.adpcm_shift_clock = sclk_reg;
	assign link.warm_reset_n = warm_n_reg;
	assign link.pcm_serial_in = pcm_tx_reg[7];
	assign link.adpcm_serial_in = adpcm_tx_reg[7];
	assign link.channel_init = ctrl_reg[`CTRL_INIT];
	assign link.channel_enable = ctrl_reg[`CTRL_EN];
	assign link.companding_law_select = ctrl_reg[`CTRL_LAW];
	assign link.rate_select_lsb = ctrl_reg[`CTRL_RATE_LSB];
	assign link.rate_select_msb = ctrl_reg[`CTRL_RATE_MSB];
	assign link.direction_select = ctrl_reg[`CTRL_DIR];
endmodule : adpcm_slot_host

// File: tb/adpcm_channel_init_reset_nop_tb_top.sv
// bench: slot host and channel core joined, checked against a model
`timescale 1ns/1ps
`include "adpcm_link_map.svh"
module adpcm_channel_init_reset_nop_tb_top;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp, init_busy;
	logic [31:0] hrdata, r;
	logic [2:0] active_channel;
	logic [31:0] seed = 32'h9042;
	logic [7:0] pred [8];
	logic [8:0] q [$];
	logic [8:0] e;
	logic [7:0] cfg;
	int err_count = 0, samples_checked = 0, cycles = 0, ptr = 0, n;
	adpcm_link_if link_i ();

	adpcm_channel_core adpcm_channel_core_i (.hclk(hclk), .hresetn(hresetn),
		.clk_en(1'b1), .link(link_i.device), .init_busy(init_busy),
		.active_channel(active_channel));
	adpcm_slot_host adpcm_slot_host_i (.hclk(hclk), .hresetn(hresetn),
		.clk_en(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .link(link_i.host));
	adpcm_link_asserts adpcm_link_asserts_i (.hclk(hclk), .hresetn(hresetn),
		.init_busy(init_busy), .channel_strobe(link_i.channel_strobe),
		.warm_reset_n(link_i.warm_reset_n),
		.pcm_shift_clock(link_i.pcm_shift_clock),
		.adpcm_shift_clock(link_i.adpcm_shift_clock),
		.pcm_serial_out_oe(link_i.pcm_serial_out_oe),
		.adpcm_serial_out_oe(link_i.adpcm_serial_out_oe));

	always #20 hclk = ~hclk;

	// hang guard: ceiling well above the ~30k cycles the run needs
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 60000) begin
			err_count++;
			print_verdict();
		end
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : print_verdict

	// one single ahb-lite transfer, entered just after a rising edge
	task automatic ahb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {20'h0, a};
		hwrite <= wr;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask : ahb

	// polls status until the host is idle; a host stuck busy shows up here
	task automatic idle();
		n = 0;
		r = 32'h1;
		while (r[0] !== 1'b0 && n < 2000) begin
			ahb(1'b0, `STATUS_OFFSET, 32'h0, r);
			n++;
		end
		check("idle", {31'h0, r[0]}, 32'h0);
	endtask : idle

	// reference channel: pipeline of two slots, stand-in transcoder
	task automatic model(input logic [15:0] tx);
		logic [4:0] m, c;
		logic [7:0] o;
		logic [1:0] rt;
		rt = cfg[5:4];
		m = rt == 2'b11 ? `MASK_40K : rt == 2'b10 ? `MASK_16K :
			rt == 2'b01 ? `MASK_24K : `MASK_32K;
		if (cfg[1] || !cfg[2]) begin
			o = cfg[6] ? 8'h00 : (cfg[3] ? 8'hd5 : 8'hff);
			if (cfg[1]) pred[ptr] = 8'h00;
		end else if (cfg[6]) begin
			c = (tx[7:3] ^ pred[ptr][7:3]) & m;
			pred[ptr] = tx[7:0];
			o = rt == 2'b11 ? {c, c[4:2]} : {c[4:1], c[4:1]};
		end else begin
			c = (rt == 2'b11 ? tx[12:8] : {tx[11:8], 1'b0}) & m;
			o = {c, 3'b000} ^ pred[ptr];
			pred[ptr] = o;
		end
		q.push_back({cfg[6], o});
		ptr = (ptr + 1) % 8;
	endtask : model

	// one slot through the registers, then compare what came back
	task automatic slot(input logic [15:0] tx);
		ahb(1'b1, `TXDATA_OFFSET, {16'h0, tx}, r);
		ahb(1'b1, `CTRL_OFFSET, {24'h0, cfg | 8'h01}, r);
		idle();
		ahb(1'b0, `STATUS_OFFSET, 32'h0, r);
		model(tx);
		check("channel", {29'h0, active_channel}, ptr);
		if (q.size() == 3) begin
			e = q.pop_front();
			if (e[8]) check("code out", r[23:16], e[7:0]);
			else check("pcm out", r[15:8], e[7:0]);
			check("seen", {30'h0, r[2:1]}, {30'h0, e[8], !e[8]});
		end else begin
			check("quiet", {30'h0, r[2:1]}, 32'h0);
		end
		ahb(1'b0, `CTRL_OFFSET, 32'h0, r);
		check("ctrl", r, {24'h0, cfg & 8'h7e});
	endtask : slot

	// every law and rate code; init all channels, then random traffic
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		ahb(1'b0, `STATUS_OFFSET, 32'h0, r);
		check("status reset", r, 32'h0);
		check("okay resp", {31'h0, hresp}, 32'h0);
		ahb(1'b0, `CTRL_OFFSET, 32'h0, r);
		check("ctrl reset", r, 32'h0);
		ahb(1'b1, 12'h00c, 32'hffffffff, r);
		ahb(1'b0, 12'h00c, 32'h0, r);
		check("unmapped", r, 32'h0);
		n = 0;
		while (init_busy !== 1'b0 && n < 3000) begin
			@(posedge hclk);
			n++;
		end
		check("por done", {31'h0, init_busy}, 32'h0);
		for (int k = 0; k < 8; k++) begin
			ahb(1'b1, `CTRL_OFFSET, 32'h80, r);
			idle();
			ptr = 0;
			q.delete();
			for (int s = 0; s < 16; s++) begin
				r = rnd();
				cfg = {1'b0, s < 8 ? s[0] : r[0], k[1:0], k[2],
					s < 8 ? 1'b1 : r[1], s < 8, 1'b0};
				slot(rnd());
			end
		end
		print_verdict();
	end
endmodule : adpcm_channel_init_reset_nop_tb_top

// File: tb/adpcm_link_asserts.sv
// checker watching the link between the slot host and the channel core
`timescale 1ns/1ps
module adpcm_link_asserts (
	input logic hclk,
	input logic hresetn,
	input logic init_busy,
	input logic channel_strobe,
	input logic warm_reset_n,
	input logic pcm_shift_clock,
	input logic adpcm_shift_clock,
	input logic pcm_serial_out_oe,
	input logic adpcm_serial_out_oe
);
	logic [11:0] por_cnt;
	logic [11:0] warm_cnt;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// counters saturate so a long run never wraps back into a window
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) por_cnt <= 12'h000;
		else if (por_cnt != 12'hfff) por_cnt <= por_cnt + 12'h001;
	end

	// edges seen since warm reset went high; idle value lies outside
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) warm_cnt <= 12'hfff;
		else if (!warm_reset_n) warm_cnt <= 12'h000;
		else if (warm_cnt != 12'hfff) warm_cnt <= warm_cnt + 12'h001;
	end

	sequence strobe_high_run;
		channel_strobe [*8];
	endsequence
	sequence strobe_low_run;
		!channel_strobe [*8];
	endsequence

	a_busy_quiet: assert property (
		!$past(warm_reset_n, 3) |->
		init_busy && !pcm_serial_out_oe && !adpcm_serial_out_oe)
		else $error("serial output driven during initialization");
	a_oe_strobe: assert property (
		!channel_strobe [*4] |-> !pcm_serial_out_oe && !adpcm_serial_out_oe)
		else $error("serial output driven while strobe low");
	a_one_driver: assert property (
		!(pcm_serial_out_oe && adpcm_serial_out_oe))
		else $error("both serial outputs driven");
	a_idle_clocks: assert property (
		!channel_strobe |-> pcm_shift_clock && adpcm_shift_clock)
		else $error("shift clock low outside slot");
	a_strobe_high: assert property (
		$rose(channel_strobe) |=> strobe_high_run)
		else $error("strobe high too short");
	a_strobe_low: assert property (
		$fell(channel_strobe) |=> strobe_low_run)
		else $error("strobe low too short");
	a_warm_pulse: assert property (
		$fell(warm_reset_n) |=> !warm_reset_n)
		else $error("warm reset pulse too short");
	a_warm_gap: assert property (
		warm_cnt < 12'd6 |-> $stable(channel_strobe))
		else $error("strobe moved too soon after warm reset");
	a_warm_busy: assert property (
		warm_cnt > 12'd3 && warm_cnt < 12'd726 |-> init_busy)
		else $error("warm initialization ended early");
	a_warm_done: assert property (
		warm_cnt == 12'd740 |-> !init_busy)
		else $error("warm initialization did not end");
	a_por_busy: assert property (
		por_cnt < 12'd1999 |-> init_busy)
		else $error("power-on initialization ended early");
	a_por_done: assert property (
		por_cnt == 12'd2003 |-> !init_busy)
		else $error("power-on initialization did not end");
endmodule : adpcm_link_asserts
